// File: design/gpio_mux_pkg.sv
// package for the pin output multiplexer: register map, field layout, codes
// assumes an 8-bit APB byte address and 32-bit data
package gpio_mux_pkg;

  localparam int NUM_PINS = 4;
  localparam int NUM_RX = 4;
  localparam int NUM_TX = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] PIN3_CTRL_IDX = 6'h13;
  localparam logic [5:0] PIN4_CTRL_IDX = 6'h14;
  localparam logic [5:0] PIN5_CTRL_IDX = 6'h15;
  localparam logic [5:0] PIN6_CTRL_IDX = 6'h16;
  localparam logic [5:0] PIN_STATE_IDX = 6'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // output source codes
  localparam logic [2:0] SRC_DEVICE = 3'h4;
  localparam logic [2:0] SRC_RESERVED = 3'h5;

  // control register layout: bits 7:5 select, 4:2 source, 1 value, 0 enable
  typedef struct packed {
    logic [2:0] signal_select;
    logic [2:0] source_select;
    logic local_value;
    logic drive_enable;
  } pin_ctrl_t;

  // receive port status; bit order matches the select codes 000 to 111
  typedef struct packed {
    logic line_valid;
    logic frame_valid;
    logic pass;
    logic lock;
    logic [3:0] remote_gpio;
  } rx_status_t;

  // transmit port status
  typedef struct packed {
    logic [3:0] rx_port_map;
    logic interrupt;
    logic synced;
    logic line_valid;
    logic frame_valid;
  } tx_status_t;

endpackage

// File: design/pin_output_mux.sv
// one pin's source and signal selection, purely combinational
// assumes all status inputs are synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none

module pin_output_mux (
  // configuration
  input wire gpio_mux_pkg::pin_ctrl_t ctrl,
  // status sources
  input wire gpio_mux_pkg::rx_status_t [gpio_mux_pkg::NUM_RX-1:0] rx,
  input wire gpio_mux_pkg::tx_status_t [gpio_mux_pkg::NUM_TX-1:0] tx,
  input wire logic [gpio_mux_pkg::NUM_RX-1:0] rx_enabled,
  input wire logic frame_sync_pulse,
  // selected level
  output logic level
);

  wire gpio_mux_pkg::rx_status_t rx_sel;
  wire gpio_mux_pkg::tx_status_t tx_sel;
  wire [3:0] lock_vec;
  wire [3:0] pass_vec;
  wire any_enabled;
  wire lock_or;
  wire lock_and;
  wire pass_and;
  wire any_mapped;
  wire tx_pass_and;
  wire tx_pass_or;
  wire [7:0] rx_vec;
  wire [7:0] dev_vec;
  wire [7:0] tx_vec;
  wire rx_level;
  wire dev_level;
  wire tx_level;

  assign rx_sel = rx[ctrl.source_select[1:0]];
  assign tx_sel = tx[ctrl.source_select[0]];

  generate
    for (genvar i = 0; i < gpio_mux_pkg::NUM_RX; i++) begin : g_vec
      assign lock_vec[i] = rx[i].lock;
      assign pass_vec[i] = rx[i].pass;
    end
  endgenerate

  // receive port signals
  assign rx_vec = rx_sel;
  assign rx_level = rx_vec[ctrl.signal_select];

  // device status; no enabled port gives low
  assign any_enabled = |rx_enabled;
  assign lock_or = |(lock_vec & rx_enabled);
  assign lock_and = any_enabled & (&(lock_vec | ~rx_enabled));
  assign pass_and = any_enabled & (&(pass_vec | ~rx_enabled));
  assign dev_vec = {3'h0, frame_sync_pulse, pass_and, lock_and, lock_or,
                    ctrl.local_value};
  assign dev_level = dev_vec[ctrl.signal_select];

  // transmit port signals; no mapped port gives low
  assign any_mapped = |tx_sel.rx_port_map;
  assign tx_pass_and = any_mapped & (&(pass_vec | ~tx_sel.rx_port_map));
  assign tx_pass_or = |(pass_vec & tx_sel.rx_port_map);
  assign tx_vec = {2'h0, tx_sel.interrupt, tx_sel.synced, tx_sel.line_valid,
                   tx_sel.frame_valid, tx_pass_or, tx_pass_and};
  assign tx_level = tx_vec[ctrl.signal_select];

  // source choice; the reserved source gives low
  assign level = (ctrl.source_select == gpio_mux_pkg::SRC_RESERVED) ? 1'b0 :
                 (ctrl.source_select == gpio_mux_pkg::SRC_DEVICE) ? dev_level :
                 ctrl.source_select[2] ? tx_level : rx_level;

endmodule

`default_nettype wire

// File: design/gpio_output_source_mux.sv
// output multiplexer and drive control for four general purpose pins
// assumes an APB master on pclk and status inputs synchronous to pclk
//
// Operation
// - The 3-bit source field picks receive port 0 to 3, device status, or transmit port 0 or 1.
// - For a receive port, the select field picks remote GPIO 0 to 3, lock, pass, frame or line valid.
// - For device status, select picks local value, OR lock, AND lock, AND pass, or frame sync.
// - For a transmit port, select picks AND or OR pass, frame valid, line valid, synced or interrupt.
// - The local value bit drives the pin when device status code zero is chosen.
// - A pin is driven only while its enable bit is set, otherwise its driver is off.
`timescale 1ns/1ps
`default_nettype none

module gpio_output_source_mux (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_mux_pkg::ADDR_W-1:0] paddr,
  input wire logic [gpio_mux_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [gpio_mux_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // status sources
  input wire gpio_mux_pkg::rx_status_t [gpio_mux_pkg::NUM_RX-1:0] rx_status,
  input wire gpio_mux_pkg::tx_status_t [gpio_mux_pkg::NUM_TX-1:0] tx_status,
  input wire logic [gpio_mux_pkg::NUM_RX-1:0] rx_enabled,
  input wire logic frame_sync_pulse,
  // pins 3 to 6, index 0 is pin 3
  output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_out,
  output logic [gpio_mux_pkg::NUM_PINS-1:0] pin_oe
);

  gpio_mux_pkg::pin_ctrl_t [gpio_mux_pkg::NUM_PINS-1:0] ctrl_ff;
  logic [gpio_mux_pkg::NUM_PINS-1:0] pin_out_ff;
  logic [gpio_mux_pkg::NUM_PINS-1:0] pin_oe_ff;
  logic [gpio_mux_pkg::DATA_W-1:0] prdata_ff;
  logic pslverr_ff;

  wire [gpio_mux_pkg::NUM_PINS-1:0] pin_level;
  wire [gpio_mux_pkg::NUM_PINS-1:0] nxt_pin_out;
  wire [gpio_mux_pkg::NUM_PINS-1:0] nxt_pin_oe;
  wire [gpio_mux_pkg::NUM_PINS-1:0] ctrl_hit;
  wire [5:0] word_idx;
  wire aligned;
  wire state_hit;
  wire mapped;
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire [gpio_mux_pkg::REG_W-1:0] ctrl_rd;
  wire [gpio_mux_pkg::REG_W-1:0] state_rd;
  wire [gpio_mux_pkg::REG_W-1:0] rd_byte;
  wire [gpio_mux_pkg::DATA_W-1:0] nxt_prdata;

  // apb decode
  assign word_idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign state_hit = aligned & (word_idx == gpio_mux_pkg::PIN_STATE_IDX);
  assign mapped = (|ctrl_hit) | state_hit;
  assign wr_en = access_phase & pwrite & pstrb[0];
  assign pready = 1'b1;

  generate
    for (genvar i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin : g_pin
      assign ctrl_hit[i] = aligned &
                           (word_idx == gpio_mux_pkg::PIN3_CTRL_IDX + 6'(i));

      pin_output_mux u_mux (
        .ctrl(ctrl_ff[i]),
        .rx(rx_status),
        .tx(tx_status),
        .rx_enabled(rx_enabled),
        .frame_sync_pulse(frame_sync_pulse),
        .level(pin_level[i])
      );

      assign nxt_pin_oe[i] = ctrl_ff[i].drive_enable;
      assign nxt_pin_out[i] = ctrl_ff[i].drive_enable & pin_level[i];

      // control register write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_ff[i] <= gpio_mux_pkg::CTRL_RESET;
        end else if (wr_en && ctrl_hit[i]) begin
          ctrl_ff[i] <= gpio_mux_pkg::pin_ctrl_t'(pwdata[7:0]);
        end
      end
    end
  endgenerate

  // read data selection
  assign ctrl_rd = ctrl_hit[0] ? ctrl_ff[0] :
                   ctrl_hit[1] ? ctrl_ff[1] :
                   ctrl_hit[2] ? ctrl_ff[2] :
                   ctrl_hit[3] ? ctrl_ff[3] : 8'h00;
  assign state_rd = {pin_oe_ff, pin_out_ff};
  assign rd_byte = state_hit ? state_rd : ctrl_rd;
  assign nxt_prdata = {24'h000000, rd_byte};

  // read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup_phase) begin
      prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
      pslverr_ff <= ~mapped;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & access_phase;

  // registered pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_ff <= 4'h0;
      pin_oe_ff <= 4'h0;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;

endmodule

`default_nettype wire

// File: verification/pin_board.sv
// board side of pins 3 to 6
// assumes pin_out and pin_oe come from the mux
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  // pin drivers
  input wire logic [3:0] pin_out, pin_oe,
  // resolved line levels
  output logic [3:0] pin_line
);
  // undriven lines fall to the pull-down
  assign pin_line = pin_oe & pin_out;
endmodule
`default_nettype wire

// File: verification/gpio_mux_sva.sv
// checker for the pin output mux
// assumes it is bound to the mux top
`timescale 1ns/1ps
`default_nettype none
module gpio_mux_sva (
  // apb
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // status and pins
  input wire gpio_mux_pkg::rx_status_t [3:0] rx_status,
  input wire gpio_mux_pkg::tx_status_t [1:0] tx_status,
  input wire logic [3:0] rx_enabled, pin_out, pin_oe,
  input wire logic frame_sync_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [52:0] stat = {rx_status, tx_status, rx_enabled, frame_sync_pulse};
  a_off_low: assert property ((pin_out & ~pin_oe) == 4'h0)
    else $error("pin high while not driven");
  a_out_cause: assert property ($changed(pin_out) |-> $past(wr, 2) || $past(stat) != $past(stat, 2))
    else $error("pin level changed without cause");
  a_oe_cause: assert property ($changed(pin_oe) |-> $past(wr, 2))
    else $error("enable changed without write");
  a_reset_off: assert property ($rose(presetn) |-> pin_oe == 4'h0)
    else $error("pin driven after reset");
  a_state_read: assert property (acc && !pwrite && paddr == 8'h80 |->
    prdata == {24'h0, $past(pin_oe), $past(pin_out)}) else $error("pin state read wrong");
  a_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
  a_unmapped_err: assert property (acc && paddr == 8'h04 |-> pslverr) else $error("no error");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
endmodule
bind gpio_output_source_mux gpio_mux_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .prdata(prdata),
  .rx_status(rx_status), .tx_status(tx_status), .rx_enabled(rx_enabled),
  .pin_out(pin_out), .pin_oe(pin_oe), .frame_sync_pulse(frame_sync_pulse)
);
`default_nettype wire

// File: verification/tb.sv
// testbench for the pin output mux
// assumes the mux, its package, checker and board model
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frame_sync_pulse = 0;
  logic pready, pslverr, err;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] rx_enabled = 4'hF, pstrb = 4'hF, pin_out, pin_oe, pin_line;
  gpio_mux_pkg::rx_status_t [3:0] rx_status = '0;
  gpio_mux_pkg::tx_status_t [1:0] tx_status = '0;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  localparam logic [7:0] base = {gpio_mux_pkg::PIN3_CTRL_IDX, 2'h0};
  always #10 pclk = ~pclk;
  gpio_output_source_mux dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_status(rx_status), .tx_status(tx_status),
    .rx_enabled(rx_enabled), .frame_sync_pulse(frame_sync_pulse), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );
  pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_line(pin_line));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pin(input int p, input logic [7:0] c, input logic e);
    apb(1'h1, base + 8'(p * 4), {24'h0, c});
    repeat (2) @(posedge pclk);
    chk("pin", {31'h0, pin_line[p]}, {31'h0, e});
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_regs;
    for (int p = 0; p < 4; p++) begin
      apb(1'h0, base + 8'(p * 4), 32'h0);
      chk("ctrl reset", rd, 32'h0);
    end
    apb(1'h0, 8'h04, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    pstrb <= 4'h0;
    apb(1'h1, base, 32'h81);
    pstrb <= 4'hF;
    apb(1'h0, base, 32'h0);
    chk("strobe off", rd, 32'h0);
  endtask
  task automatic t_enable;
    pin(1, 8'h12, 1'h0);
    chk("oe off", {28'h0, pin_oe}, 32'h0);
    apb(1'h0, base + 8'h04, 32'h0);
    chk("ctrl rw", rd, 32'h12);
    pin(1, 8'h13, 1'h1);
    apb(1'h0, 8'h80, 32'h0);
    chk("pin state", rd, 32'h22);
  endtask
  task automatic t_rx;
    rx_status <= 32'hC3A55A3C;
    @(posedge pclk);
    for (int s = 0; s < 4; s++)
      for (int b = 0; b < 8; b++)
        pin(s, {3'(b), 3'(s), 2'h1}, rx_status[s][b]);
  endtask
  task automatic t_dev_tx;
    rx_enabled <= 4'h3;
    rx_status <= 32'h30;
    frame_sync_pulse <= 1'h1;
    for (int b = 0; b < 8; b++) pin(2, {3'(b), 5'h11}, b == 1 || b == 4);
    rx_status <= 32'h20;
    tx_status <= 16'h3A01;
    for (int b = 0; b < 8; b++) pin(3, {3'(b), 5'h1D}, b == 1 || b == 3 || b == 5);
    pin(0, 8'h59, 1'h1);
    pin(0, 8'h35, 1'h0);
    chk("reserved oe", {31'h0, pin_oe[0]}, 32'h1);
  endtask
  always @(posedge pclk) if (++cyc > 5000) begin
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_enable;
    t_rx;
    t_dev_tx;
    complete_run;
  end
endmodule
`default_nettype wire
